//--- ipis_top.sv
// interrupt request pins, acknowledge pin and init fault status
`timescale 1ns/1ps
`default_nettype none
// Function
// - fault active while self-test runs after reset
// - self-test pass releases fault, starts checksum
// - eight memory words must sum to zero
// - checksum fail holds fault until reset
// - checksum pass keeps fault inactive, continues
// - control bit picks message or interrupt
// - second pin is plain qualified interrupt
// - third pin interrupt or controller request
// - fourth pin interrupt or open-drain acknowledge
// - acknowledge latched, stable during data phase
// - in reset take straps, ignore other pins, outputs inactive
module ipis_top
    import ipis_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic async_mode,
    input wire logic req0_is_msg,
    input wire logic req2_is_ext_ctrl,
    input wire logic req3_is_ack,
    input wire logic msg_or_irq_req0_b,
    input wire logic irq_req1_b,
    input wire logic irq2_or_ext_ctrl_req_b,
    input wire logic irq3_or_ack_in_b,
    input wire logic bad_access_in_b,
    input wire logic irq_ack_req,
    input wire logic data_phase_cycle,
    input wire logic selftest_done,
    input wire logic selftest_pass,
    input wire logic mem_rd_valid,
    input wire logic [IPIS_WORD_W-1:0] mem_rd_data,
    output logic interagent_message,
    output logic [IPIS_NUM_REQ-1:0] irq_pulse,
    output logic ext_ctrl_request,
    output logic irq3_or_ack_out,
    output logic irq3_or_ack_oe_b,
    output logic init_fault_out,
    output logic init_fault_oe_b,
    output logic selftest_start,
    output logic mem_rd_req,
    output logic [IPIS_IDX_W-1:0] mem_rd_idx,
    output logic init_ok,
    output logic init_by_self,
    output logic req0_low_at_reset
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: first stage read only by the second
    logic [IPIS_NUM_REQ-1:0] pin_act;
    logic [IPIS_NUM_REQ-1:0] sync1;
    logic [IPIS_NUM_REQ-1:0] sync2;
    logic bad1;
    logic bad2;
    assign pin_act = ~{irq3_or_ack_in_b, irq2_or_ext_ctrl_req_b, irq_req1_b, msg_or_irq_req0_b};

    always_ff @(posedge clk_sys) begin
        if (ce) begin
            sync1 <= pin_act;
            sync2 <= sync1;
            bad1 <= bad_access_in_b;
            bad2 <= bad1;
        end
    end

    // straps taken while reset is held; other pins ignored then
    always_ff @(posedge clk_sys) begin
        if (ce && !rst_b) begin
            init_by_self <= bad2;
            req0_low_at_reset <= sync2[IPIS_CH_MSG];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    ipis_req_if rq ();
    // acknowledge mode masks the fourth pin so our own drive does not read back while the mode is set;
    // mask lingers two cycles, one fewer than our last pull stays in the synchroniser, so in sync mode a pull cut off by the mode dropping can qualify
    logic ack_mode_d1;
    logic ack_mode_d2;
    logic ack_mask;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ack_mode_d1 <= 1'b0;
            ack_mode_d2 <= 1'b0;
        end else if (ce) begin
            ack_mode_d1 <= req3_is_ack;
            ack_mode_d2 <= ack_mode_d1;
        end
    end
    assign ack_mask = req3_is_ack | ack_mode_d1 | ack_mode_d2;
    assign rq.req_act = {sync2[IPIS_CH_ACK] & ~ack_mask, sync2[IPIS_CH_EXT:0]};
    assign rq.async_mode = async_mode;

    ipis_qual u_qual (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ce(ce),
        .rq(rq)
    );

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            interagent_message <= 1'b0;
            irq_pulse <= '0;
            ext_ctrl_request <= 1'b0;
        end else if (ce) begin
            interagent_message <= rq.req_hit[IPIS_CH_MSG] & req0_is_msg;
            irq_pulse[0] <= rq.req_hit[IPIS_CH_MSG] & ~req0_is_msg;
            irq_pulse[1] <= rq.req_hit[1];
            irq_pulse[2] <= rq.req_hit[IPIS_CH_EXT] & ~req2_is_ext_ctrl;
            ext_ctrl_request <= rq.req_hit[IPIS_CH_EXT] & req2_is_ext_ctrl;
            irq_pulse[3] <= rq.req_hit[IPIS_CH_ACK];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // acknowledge pin, open drain: pulls low only
    logic ack_lat;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ack_lat <= 1'b0;
        end else if (ce && !data_phase_cycle) begin
            ack_lat <= irq_ack_req & req3_is_ack;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irq3_or_ack_out <= 1'b0;
            irq3_or_ack_oe_b <= 1'b1;
        end else if (ce) begin
            irq3_or_ack_out <= 1'b0;
            irq3_or_ack_oe_b <= ~(req3_is_ack & (data_phase_cycle ? ack_lat : irq_ack_req));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // init sequence
    ipis_init_t state;
    logic [IPIS_WORD_W-1:0] sum;
    logic [IPIS_WORD_W-1:0] next_sum;
    assign next_sum = sum + mem_rd_data;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state <= IPIS_ST_IDLE;
        end else if (ce) begin
            case (state)
                IPIS_ST_IDLE: state <= IPIS_ST_SELFTEST;
                IPIS_ST_SELFTEST: begin
                    if (selftest_done) begin
                        // a failed self-test never reaches the bus
                        state <= selftest_pass ? IPIS_ST_CKSUM : IPIS_ST_FAIL;
                    end
                end
                IPIS_ST_CKSUM: begin
                    if (mem_rd_valid && mem_rd_idx == IPIS_CKSUM_LAST) begin
                        state <= (next_sum == IPIS_SUM_ZERO) ? IPIS_ST_PASS : IPIS_ST_FAIL;
                    end
                end
                IPIS_ST_PASS: state <= IPIS_ST_PASS;
                IPIS_ST_FAIL: state <= IPIS_ST_FAIL;
                default: state <= IPIS_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sum <= IPIS_SUM_ZERO;
            mem_rd_idx <= '0;
        end else if (ce && state == IPIS_ST_CKSUM && mem_rd_valid) begin
            sum <= next_sum;
            mem_rd_idx <= mem_rd_idx + 3'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            init_fault_out <= 1'b0;
            init_fault_oe_b <= 1'b1;
            selftest_start <= 1'b0;
            mem_rd_req <= 1'b0;
            init_ok <= 1'b0;
        end else if (ce) begin
            init_fault_out <= 1'b0;
            selftest_start <= (state == IPIS_ST_IDLE);
            init_ok <= (state == IPIS_ST_PASS);
            mem_rd_req <= (state == IPIS_ST_CKSUM)
                && !(mem_rd_valid && mem_rd_idx == IPIS_CKSUM_LAST);
            init_fault_oe_b <= !((state == IPIS_ST_IDLE)
                || (state == IPIS_ST_SELFTEST && !(selftest_done && selftest_pass))
                || (state == IPIS_ST_FAIL)
                || (state == IPIS_ST_CKSUM && mem_rd_valid
                    && mem_rd_idx == IPIS_CKSUM_LAST && next_sum != IPIS_SUM_ZERO));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    chk_fault_in_test: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce && state == IPIS_ST_SELFTEST && !selftest_done |=> !init_fault_oe_b)
        else $error("fault not driven during self-test");
    chk_fault_release: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce && state == IPIS_ST_SELFTEST && selftest_done && selftest_pass
        |=> init_fault_oe_b && state == IPIS_ST_CKSUM)
        else $error("fault not released after self-test pass");
    chk_cksum_fail_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state == IPIS_ST_FAIL |=> !init_fault_oe_b [*4])
        else $error("fault not held after checksum fail");
    chk_cksum_pass: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state == IPIS_ST_PASS |-> init_fault_oe_b)
        else $error("fault active after checksum pass");
    chk_cksum_result: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce && state == IPIS_ST_CKSUM && mem_rd_valid && mem_rd_idx == IPIS_CKSUM_LAST
        |=> (state == IPIS_ST_PASS) == ($past(next_sum) == IPIS_SUM_ZERO))
        else $error("checksum verdict wrong");
    chk_msg_route: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce && rq.req_hit[IPIS_CH_MSG] |=> interagent_message == $past(req0_is_msg)
        && irq_pulse[0] == !$past(req0_is_msg))
        else $error("first request misrouted");
    chk_ext_route: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce && rq.req_hit[IPIS_CH_EXT] |=> ext_ctrl_request == $past(req2_is_ext_ctrl))
        else $error("third request misrouted");
    chk_ack_stable: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce && data_phase_cycle && $past(data_phase_cycle) |-> $stable(ack_lat))
        else $error("acknowledge changed in data phase");
    chk_ack_no_irq: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $past(req3_is_ack) || $past(req3_is_ack, 2) || $past(req3_is_ack, 3)
        |-> !rq.req_hit[IPIS_CH_ACK])
        else $error("fourth pin qualified in acknowledge mode");
    chk_async_width: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ce && async_mode && rq.req_hit[1] |-> $past(rq.req_act[1], 2))
        else $error("async request shorter than two cycles");
    chk_reset_outputs: assert property (@(posedge clk_sys)
        $past(!rst_b) && !rst_b |-> init_fault_oe_b && irq3_or_ack_oe_b && irq_pulse == '0)
        else $error("outputs active during reset");
endmodule
`default_nettype wire

//--- ipis_pkg.sv
// constants shared by the interrupt pin and init status block
package ipis_pkg;
    localparam int unsigned IPIS_NUM_REQ = 4;
    localparam int unsigned IPIS_CNT_W = 2;
    localparam logic [1:0] IPIS_SYNC_MIN_LO = 2'h1;
    localparam logic [1:0] IPIS_SYNC_MIN_HI = 2'h1;
    localparam logic [1:0] IPIS_ASYNC_MIN_LO = 2'h2;
    localparam logic [1:0] IPIS_ASYNC_MIN_HI = 2'h2;
    localparam logic [1:0] IPIS_CNT_MAX = 2'h3;
    localparam int unsigned IPIS_WORD_W = 32;
    localparam int unsigned IPIS_IDX_W = 3;
    localparam logic [2:0] IPIS_CKSUM_LAST = 3'h7;
    localparam logic [31:0] IPIS_SUM_ZERO = 32'h0000_0000;
    localparam int unsigned IPIS_CH_MSG = 0;
    localparam int unsigned IPIS_CH_EXT = 2;
    localparam int unsigned IPIS_CH_ACK = 3;
    typedef enum logic [2:0] {
        IPIS_ST_IDLE,
        IPIS_ST_SELFTEST,
        IPIS_ST_CKSUM,
        IPIS_ST_PASS,
        IPIS_ST_FAIL
    } ipis_init_t;
endpackage

//--- ipis_req_if.sv
// carrier between the top and the request qualifier
`timescale 1ns/1ps
`default_nettype none
interface ipis_req_if;
    import ipis_pkg::*;
    logic [IPIS_NUM_REQ-1:0] req_act;
    logic async_mode;
    logic [IPIS_NUM_REQ-1:0] req_hit;
    modport top (output req_act, output async_mode, input req_hit);
    modport qual (input req_act, input async_mode, output req_hit);
endinterface
`default_nettype wire

//--- ipis_qual.sv
// inactive-then-active pattern qualifier for the request pins
`timescale 1ns/1ps
`default_nettype none
module ipis_qual
    import ipis_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    ipis_req_if.qual rq
);
    logic [1:0] min_lo;
    logic [1:0] min_hi;
    assign min_lo = rq.async_mode ? IPIS_ASYNC_MIN_LO : IPIS_SYNC_MIN_LO;
    assign min_hi = rq.async_mode ? IPIS_ASYNC_MIN_HI : IPIS_SYNC_MIN_HI;

    ////////////////////////////////////////////////////////////////////////////
    genvar g;
    for (g = 0; g < IPIS_NUM_REQ; g++) begin : g_ch
        logic [1:0] lo_cnt;
        logic [1:0] hi_cnt;
        logic armed;
        logic hit;
        logic [1:0] next_hi;
        assign next_hi = hi_cnt + 2'h1;
        // one pulse per request; a pin stuck active never repeats
        always_ff @(posedge clk_sys) begin
            if (!rst_b) begin
                lo_cnt <= 2'h0;
                hi_cnt <= 2'h0;
                armed <= 1'b0;
                hit <= 1'b0;
            end else if (ce) begin
                hit <= 1'b0;
                if (!rq.req_act[g]) begin
                    hi_cnt <= 2'h0;
                    if (lo_cnt != IPIS_CNT_MAX) begin
                        lo_cnt <= lo_cnt + 2'h1;
                    end
                    // a short inactive gap disarms: the pattern must be unbroken
                    armed <= (lo_cnt == IPIS_CNT_MAX) || (lo_cnt + 2'h1 >= min_lo);
                end else begin
                    lo_cnt <= 2'h0;
                    if (hi_cnt != IPIS_CNT_MAX) begin
                        hi_cnt <= next_hi;
                    end
                    if (armed && next_hi >= min_hi) begin
                        hit <= 1'b1;
                        armed <= 1'b0;
                    end
                end
            end
        end
        assign rq.req_hit[g] = hit;
    end
endmodule
`default_nettype wire

//--- ipis_src_model.sv
// model of the external interrupt sources driving the request pins
`timescale 1ns/1ps
`default_nettype none
module ipis_src_model
    import ipis_pkg::*;
(
    input wire logic clk_sys,
    output logic [IPIS_NUM_REQ-1:0] req_b
);
    // pins idle at the pull-up level, first pin high through reset
    initial req_b = 4'hf;

    // held active for lo cycles, then an inactive idle follows every pull
    task automatic pull(input int ch, input int lo);
        @(negedge clk_sys);
        req_b[ch] = 1'b0;
        repeat (lo) @(negedge clk_sys);
        req_b[ch] = 1'b1;
        // gap keeps the next request legal in either mode
        repeat (4) @(negedge clk_sys);
    endtask
endmodule
`default_nettype wire

//--- ipis_tb_top.sv
// self-checking bench for the interrupt pin and init status block
`timescale 1ns/1ps
`default_nettype none
module ipis_tb_top
    import ipis_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic async_mode = 1'b0;
    logic req0_is_msg = 1'b0;
    logic req2_is_ext_ctrl = 1'b0;
    logic req3_is_ack = 1'b0;
    logic bad_access_in_b = 1'b1;
    logic irq_ack_req = 1'b0;
    logic data_phase_cycle = 1'b0;
    logic selftest_done = 1'b0;
    logic selftest_pass = 1'b0;
    logic mem_rd_valid = 1'b0;
    logic [IPIS_WORD_W-1:0] mem_rd_data = 32'h0000_0000;
    wire logic [IPIS_NUM_REQ-1:0] src_b;
    wire logic irq3_pin;
    logic interagent_message, ext_ctrl_request, irq3_or_ack_out, irq3_or_ack_oe_b;
    logic init_fault_out, init_fault_oe_b, selftest_start, mem_rd_req;
    logic init_ok, init_by_self, req0_low_at_reset;
    logic [IPIS_NUM_REQ-1:0] irq_pulse;
    logic [IPIS_IDX_W-1:0] mem_rd_idx;
    int cnt[6] = '{default: 0};
    int err_count = 0;
    int cmp_count = 0;

    always #2.5 clk_sys = ~clk_sys;
    // open-drain wire: pull-up unless either party sinks it
    assign irq3_pin = (irq3_or_ack_oe_b ? 1'b1 : irq3_or_ack_out) & src_b[3];

    ipis_src_model u_src (.clk_sys(clk_sys), .req_b(src_b));

    ipis_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .async_mode(async_mode),
        .req0_is_msg(req0_is_msg), .req2_is_ext_ctrl(req2_is_ext_ctrl),
        .req3_is_ack(req3_is_ack), .msg_or_irq_req0_b(src_b[0]), .irq_req1_b(src_b[1]),
        .irq2_or_ext_ctrl_req_b(src_b[2]), .irq3_or_ack_in_b(irq3_pin),
        .bad_access_in_b(bad_access_in_b), .irq_ack_req(irq_ack_req),
        .data_phase_cycle(data_phase_cycle), .selftest_done(selftest_done),
        .selftest_pass(selftest_pass), .mem_rd_valid(mem_rd_valid),
        .mem_rd_data(mem_rd_data), .interagent_message(interagent_message),
        .irq_pulse(irq_pulse), .ext_ctrl_request(ext_ctrl_request),
        .irq3_or_ack_out(irq3_or_ack_out), .irq3_or_ack_oe_b(irq3_or_ack_oe_b),
        .init_fault_out(init_fault_out), .init_fault_oe_b(init_fault_oe_b),
        .selftest_start(selftest_start), .mem_rd_req(mem_rd_req), .mem_rd_idx(mem_rd_idx),
        .init_ok(init_ok), .init_by_self(init_by_self),
        .req0_low_at_reset(req0_low_at_reset));

    // pulse tally: 0..3 interrupts, 4 message, 5 controller request
    always @(posedge clk_sys) begin
        for (int i = 0; i < 4; i++) cnt[i] += int'(irq_pulse[i] === 1'b1);
        cnt[4] += int'(interagent_message === 1'b1);
        cnt[5] += int'(ext_ctrl_request === 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic stop_test();
        if (err_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(negedge clk_sys);
        rst_b = 1'b0;
        repeat (20) @(negedge clk_sys);
        chk("fault oe in reset", 32'h1, 32'(init_fault_oe_b));
        chk("ack oe in reset", 32'h1, 32'(irq3_or_ack_oe_b));
        chk("pulses in reset", 32'h0, 32'({irq_pulse, interagent_message, mem_rd_req}));
        chk("init strap", 32'(bad_access_in_b), 32'(init_by_self));
        chk("req0 low strap", 32'h0, 32'(req0_low_at_reset));
        rst_b = 1'b1;
    endtask

    // words sum to zero unless bad adds one to the last
    task automatic init_seq(input logic bad);
        bad_access_in_b = !bad;
        do_reset();
        @(negedge clk_sys);
        chk("self-test start", 32'h1, 32'(selftest_start));
        repeat (5) @(negedge clk_sys);
        chk("fault during self-test", 32'h0, 32'({init_fault_oe_b, init_fault_out}));
        selftest_done = 1'b1;
        selftest_pass = 1'b1;
        @(negedge clk_sys);
        selftest_done = 1'b0;
        @(negedge clk_sys);
        chk("fault after self-test", 32'h1, 32'(init_fault_oe_b));
        @(negedge clk_sys);
        chk("checksum read", 32'h1, 32'(mem_rd_req));
        for (int k = 0; k < 8; k++) begin
            chk("word index", 32'(k), 32'(mem_rd_idx));
            mem_rd_valid = 1'b1;
            mem_rd_data = (k < 7) ? 32'(k + 1) : 32'hffff_ffe4 + 32'(bad);
            @(negedge clk_sys);
        end
        mem_rd_valid = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk("read stopped", 32'h0, 32'(mem_rd_req));
        chk("init ok", 32'(!bad), 32'(init_ok));
        repeat (20) @(negedge clk_sys);
        chk("fault after checksum", 32'(!bad), 32'(init_fault_oe_b));
    endtask

    task automatic req_case(input int ch, input int lo, input int out, input int exp,
                            input int alt);
        int b0 = cnt[out];
        int b1 = cnt[alt];
        u_src.pull(ch, lo);
        repeat (8) @(negedge clk_sys);
        chk("request pulses", 32'(exp), 32'(cnt[out] - b0));
        chk("other pulses", 32'h0, 32'(cnt[alt] - b1));
    endtask

    task automatic ack_case();
        int b = cnt[3];
        irq_ack_req = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("ack in irq mode", 32'h1, 32'(irq3_or_ack_oe_b));
        req3_is_ack = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("ack asserted", 32'h0, 32'({irq3_or_ack_oe_b, irq3_or_ack_out}));
        data_phase_cycle = 1'b1;
        @(negedge clk_sys);
        irq_ack_req = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk("ack held in data phase", 32'h0, 32'(irq3_or_ack_oe_b));
        data_phase_cycle = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk("ack released", 32'h1, 32'(irq3_or_ack_oe_b));
        chk("no irq from ack pin", 32'h0, 32'(cnt[3] - b));
        req3_is_ack = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk("no irq after ack mode", 32'h0, 32'(cnt[3] - b));
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        init_seq(1'b0);
        req_case(0, 1, 0, 1, 4);
        req0_is_msg = 1'b1;
        req_case(0, 1, 4, 1, 0);
        req0_is_msg = 1'b0;
        // held low for long still yields a single pulse
        req_case(1, 10, 1, 1, 0);
        req_case(2, 1, 2, 1, 5);
        req2_is_ext_ctrl = 1'b1;
        req_case(2, 1, 5, 1, 2);
        req2_is_ext_ctrl = 1'b0;
        req_case(3, 1, 3, 1, 2);
        async_mode = 1'b1;
        req_case(1, 1, 1, 0, 2);
        req_case(1, 2, 1, 1, 2);
        async_mode = 1'b0;
        ack_case();
        // frozen clock enable swallows a request
        ce = 1'b0;
        req_case(1, 2, 1, 0, 0);
        ce = 1'b1;
        init_seq(1'b1);
        stop_test();
    end

    // run needs well under 2000 cycles
    initial begin
        #100000;
        err_count++;
        stop_test();
    end
endmodule
`default_nettype wire
